// ---- sync_timing_params.svh ----
// sync_timing_params.svh: object indices, subindices, reset values and timing for the monitor.
// assumes it is included by bare name wherever the monitor's constants are needed.
`ifndef SYNC_TIMING_PARAMS_SVH
`define SYNC_TIMING_PARAMS_SVH

// local timebase: one clk period in ns (40 MHz)
`define STM_CLK_PERIOD_NS 32'd25

// object indices
`define STM_IDX_OUT 16'h1c32
`define STM_IDX_IN 16'h1c33

// subindices, shared by both parameter sets
`define STM_SUB_COUNT 8'h00
`define STM_SUB_MODE 8'h01
`define STM_SUB_CYCLE 8'h02
`define STM_SUB_SHIFT 8'h03
`define STM_SUB_SUPPORTED 8'h04
`define STM_SUB_MIN_CYCLE 8'h05
`define STM_SUB_CALC_COPY 8'h06
`define STM_SUB_MIN_DELAY 8'h07
`define STM_SUB_COMMAND 8'h08
`define STM_SUB_MAX_DELAY 8'h09
`define STM_SUB_MISSED 8'h0b
`define STM_SUB_OVERRUN 8'h0c
`define STM_SUB_SHORT 8'h0d
`define STM_SUB_LATE 8'h20

// reset values
`define STM_RST_PARAM_COUNT 8'h20
`define STM_RST_OUT_MODE 16'h0001
`define STM_RST_IN_MODE 16'h0022
`define STM_RST_CYCLE 32'h000f4240
`define STM_RST_MIN_CYCLE 32'h000186a0
`define STM_SUPPORTED_MODES 16'h0003

// sync-mode codes
`define STM_MODE_FREE_RUN 16'h0000
`define STM_MODE_MGR_EVENT 16'h0001
`define STM_MODE_SYNC0 16'h0002
`define STM_MODE_SYNC1 16'h0003
`define STM_MODE_OUT_MGR_EVENT 16'h0022

// measurement command codes
`define STM_CMD_STOP 16'h0000
`define STM_CMD_START 16'h0001

// measured-value slots
`define STM_M_OUT_SHIFT 0
`define STM_M_OUT_MIN_CYCLE 1
`define STM_M_OUT_CALC 2
`define STM_M_OUT_DELAY 3
`define STM_M_IN_SHIFT 4
`define STM_M_IN_MIN_CYCLE 5
`define STM_M_IN_CALC 6
`define STM_M_IN_DELAY 7
`define STM_M_SLOTS 8

// diagnostic counter slots
`define STM_C_OUT_MISSED 0
`define STM_C_OUT_OVERRUN 1
`define STM_C_OUT_SHORT 2
`define STM_C_IN_MISSED 3
`define STM_C_IN_OVERRUN 4
`define STM_C_IN_SHORT 5
`define STM_C_SLOTS 6
`define STM_CNT_MAX 16'hffff

`endif

// ---- stm_pkg.sv ----
// stm_pkg.sv: carrier types of the sync timing monitor.
// assumes nothing beyond a SystemVerilog compiler.
package stm_pkg;

    // one object-dictionary access from the mailbox side
    typedef struct packed {
        logic write;
        logic [15:0] index;
        logic [7:0] subindex;
        logic [31:0] wdata;
    } od_req_t;

    // one-cycle event pulses from the terminal's sync and process logic
    typedef struct packed {
        logic sync0;
        logic sync1;
        logic sm_out;
        logic sm_in;
        logic out_applied;
        logic in_sampled;
        logic in_ready;
    } sync_evt_t;

endpackage : stm_pkg

// ---- sync_timing_monitor.sv ----
// sync_timing_monitor.sv: output and input synchronisation parameter sets, measurement, diagnostics.
// assumes event pulses and od requests are synchronous to clk, one cycle each.
`include "sync_timing_params.svh"

module sync_timing_monitor (
    input wire logic clk,
    input wire logic srst,
    input wire logic od_req_valid,
    input wire stm_pkg::od_req_t od_req,
    output logic od_ack,
    output logic od_err,
    output logic [31:0] od_rdata,
    input wire stm_pkg::sync_evt_t evt,
    input wire logic op_state,
    output logic out_dc_mode,
    output logic in_dc_mode,
    output logic measuring
);

    logic [31:0] now_ff;
    logic [31:0] t_sync0_ff;
    logic [31:0] t_sync1_ff;
    logic [31:0] t_smout_ff;
    logic [31:0] t_sample_ff;
    logic [31:0] t_out_start_ff;
    logic [31:0] t_in_start_ff;
    logic [15:0] out_mode_ff;
    logic [15:0] in_mode_ff;
    logic [31:0] out_cycle_ff;
    logic [31:0] in_cycle_ff;
    logic [15:0] out_cmd_ff;
    logic [15:0] in_cmd_ff;
    logic [31:0] meas_ff [`STM_M_SLOTS];
    logic [31:0] meas_val [`STM_M_SLOTS];
    logic [`STM_M_SLOTS-1:0] meas_hit;
    logic [15:0] cnt_ff [`STM_C_SLOTS];
    logic [`STM_C_SLOTS-1:0] cnt_inc;
    logic out_busy_ff;
    logic in_busy_ff;
    logic out_seen_ff;
    logic in_seen_ff;
    logic out_late_ff;
    logic in_late_ff;
    logic out_start;
    logic in_start;
    logic in_mgr_evt;
    logic start_meas;
    logic wr;
    logic od_ack_ff;
    logic od_err_ff;
    logic [31:0] od_rdata_ff;
    logic nxt_err;
    logic [31:0] nxt_rdata;
    logic [31:0] since_sync0;

    assign out_dc_mode = (out_mode_ff == `STM_MODE_SYNC0) || (out_mode_ff == `STM_MODE_SYNC1);
    assign in_dc_mode = (in_mode_ff == `STM_MODE_SYNC0) || (in_mode_ff == `STM_MODE_SYNC1);
    assign measuring = (out_cmd_ff == `STM_CMD_START) || (in_cmd_ff == `STM_CMD_START);
    assign od_ack = od_ack_ff;
    assign od_err = od_err_ff;
    assign od_rdata = od_rdata_ff;
    assign wr = od_req_valid && od_req.write;
    assign start_meas = wr && !measuring && (od_req.wdata[15:0] == `STM_CMD_START)
        && (od_req.subindex == `STM_SUB_COMMAND)
        && ((od_req.index == `STM_IDX_OUT) || (od_req.index == `STM_IDX_IN));

    // cycle start: SYNC0 in DC mode, the relevant manager event otherwise
    assign in_mgr_evt = (in_mode_ff == `STM_MODE_OUT_MGR_EVENT) ? evt.sm_out : evt.sm_in;
    assign out_start = out_dc_mode ? evt.sync0 : evt.sm_out;
    assign in_start = in_dc_mode ? evt.sync0 : in_mgr_evt;
    assign since_sync0 = now_ff - t_sync0_ff;

    // local timebase in ns; wraps harmlessly since only differences are used
    always_ff @(posedge clk) begin
        if (srst) begin
            now_ff <= 32'h0000_0000;
        end else begin
            now_ff <= now_ff + `STM_CLK_PERIOD_NS;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            t_sync0_ff <= 32'h0000_0000;
            t_sync1_ff <= 32'h0000_0000;
            t_smout_ff <= 32'h0000_0000;
            t_sample_ff <= 32'h0000_0000;
            t_out_start_ff <= 32'h0000_0000;
            t_in_start_ff <= 32'h0000_0000;
        end else begin
            if (evt.sync0) t_sync0_ff <= now_ff;
            if (evt.sync1) t_sync1_ff <= now_ff;
            if (evt.sm_out) t_smout_ff <= now_ff;
            if (evt.in_sampled) t_sample_ff <= now_ff;
            if (out_start) t_out_start_ff <= now_ff;
            if (in_start) t_in_start_ff <= now_ff;
        end
    end

    always_comb begin
        meas_hit = '0;
        meas_hit[`STM_M_OUT_SHIFT] = evt.out_applied && out_dc_mode;
        meas_hit[`STM_M_OUT_MIN_CYCLE] = evt.out_applied;
        meas_hit[`STM_M_OUT_CALC] = evt.out_applied;
        meas_hit[`STM_M_OUT_DELAY] = evt.out_applied && out_dc_mode;
        meas_hit[`STM_M_IN_SHIFT] = evt.in_sampled && in_dc_mode;
        meas_hit[`STM_M_IN_MIN_CYCLE] = evt.in_ready;
        meas_hit[`STM_M_IN_CALC] = evt.in_ready;
        meas_hit[`STM_M_IN_DELAY] = evt.in_sampled && in_dc_mode;
        meas_val[`STM_M_OUT_SHIFT] = now_ff - t_sync0_ff;
        meas_val[`STM_M_OUT_MIN_CYCLE] = now_ff - t_out_start_ff;
        meas_val[`STM_M_OUT_CALC] = now_ff - t_smout_ff;
        meas_val[`STM_M_OUT_DELAY] = now_ff - t_sync1_ff;
        meas_val[`STM_M_IN_SHIFT] = now_ff - t_sync0_ff;
        meas_val[`STM_M_IN_MIN_CYCLE] = now_ff - t_in_start_ff;
        meas_val[`STM_M_IN_CALC] = now_ff - t_sample_ff;
        meas_val[`STM_M_IN_DELAY] = now_ff - t_sync1_ff;
    end

    // measured maxima; min cycle slots keep the supported figure until a measurement start clears them
    for (genvar m = 0; m < `STM_M_SLOTS; m++) begin : g_meas
        localparam logic [31:0] RST_VAL =
            ((m == `STM_M_OUT_MIN_CYCLE) || (m == `STM_M_IN_MIN_CYCLE)) ?
            `STM_RST_MIN_CYCLE : 32'h0000_0000;
        always_ff @(posedge clk) begin
            if (srst) begin
                meas_ff[m] <= RST_VAL;
            end else if (start_meas) begin
                meas_ff[m] <= 32'h0000_0000;
            end else if (measuring && meas_hit[m] && (meas_val[m] > meas_ff[m])) begin
                meas_ff[m] <= meas_val[m];
            end
        end
    end

    // manager event seen since last SYNC0; set wins over clear
    always_ff @(posedge clk) begin
        if (srst) begin
            out_seen_ff <= 1'b0;
            in_seen_ff <= 1'b0;
        end else begin
            out_seen_ff <= evt.sm_out || (out_seen_ff && !evt.sync0);
            in_seen_ff <= in_mgr_evt || (in_seen_ff && !evt.sync0);
        end
    end

    // cycle busy from start to completion; a new start re-arms it
    always_ff @(posedge clk) begin
        if (srst) begin
            out_busy_ff <= 1'b0;
            in_busy_ff <= 1'b0;
        end else begin
            out_busy_ff <= out_start || (out_busy_ff && !evt.out_applied);
            in_busy_ff <= in_start || (in_busy_ff && !evt.in_ready);
        end
    end

    always_comb begin
        cnt_inc = '0;
        cnt_inc[`STM_C_OUT_MISSED] = op_state && out_dc_mode && evt.sync0 && !out_seen_ff;
        cnt_inc[`STM_C_IN_MISSED] = op_state && in_dc_mode && evt.sync0 && !in_seen_ff;
        cnt_inc[`STM_C_OUT_OVERRUN] = op_state && out_start && out_busy_ff;
        cnt_inc[`STM_C_IN_OVERRUN] = op_state && in_start && in_busy_ff;
        cnt_inc[`STM_C_OUT_SHORT] = out_dc_mode && evt.sync1
            && (since_sync0 < meas_ff[`STM_M_OUT_CALC]);
        cnt_inc[`STM_C_IN_SHORT] = in_dc_mode && evt.sync1
            && (since_sync0 < meas_ff[`STM_M_IN_CALC]);
    end

    for (genvar c = 0; c < `STM_C_SLOTS; c++) begin : g_cnt
        always_ff @(posedge clk) begin
            if (srst) begin
                cnt_ff[c] <= 16'h0000;
            end else if (cnt_inc[c] && (cnt_ff[c] != `STM_CNT_MAX)) begin
                cnt_ff[c] <= cnt_ff[c] + 16'h0001;
            end
        end
    end

    // late in DC mode when the previous cycle had not completed (outputs applied, inputs ready) by the next start
    always_ff @(posedge clk) begin
        if (srst) begin
            out_late_ff <= 1'b0;
            in_late_ff <= 1'b0;
        end else begin
            if (!out_dc_mode) out_late_ff <= 1'b0;
            else if (out_start) out_late_ff <= out_busy_ff;
            if (!in_dc_mode) in_late_ff <= 1'b0;
            else if (in_start) in_late_ff <= in_busy_ff;
        end
    end

    // writable objects; illegal values are refused and the object keeps its value
    always_ff @(posedge clk) begin
        if (srst) begin
            out_mode_ff <= `STM_RST_OUT_MODE;
            in_mode_ff <= `STM_RST_IN_MODE;
            out_cycle_ff <= `STM_RST_CYCLE;
            in_cycle_ff <= `STM_RST_CYCLE;
            out_cmd_ff <= `STM_CMD_STOP;
            in_cmd_ff <= `STM_CMD_STOP;
        end else if (wr && !nxt_err) begin
            case (od_req.subindex)
                `STM_SUB_MODE: begin
                    if (od_req.index == `STM_IDX_OUT) out_mode_ff <= od_req.wdata[15:0];
                    else in_mode_ff <= od_req.wdata[15:0];
                end
                `STM_SUB_CYCLE: begin
                    if (od_req.index == `STM_IDX_OUT) out_cycle_ff <= od_req.wdata;
                    else in_cycle_ff <= od_req.wdata;
                end
                `STM_SUB_COMMAND: begin
                    if (od_req.index == `STM_IDX_OUT) out_cmd_ff <= od_req.wdata[15:0];
                    else in_cmd_ff <= od_req.wdata[15:0];
                end
                default: begin
                end
            endcase
        end
    end

    // read mux and access check; any write to a read-only object is refused
    always_comb begin
        logic is_out;
        logic [15:0] mode_w;
        is_out = (od_req.index == `STM_IDX_OUT);
        mode_w = od_req.wdata[15:0];
        nxt_rdata = 32'h0000_0000;
        nxt_err = 1'b0;
        if (!is_out && (od_req.index != `STM_IDX_IN)) begin
            nxt_err = 1'b1;
        end else begin
            case (od_req.subindex)
                `STM_SUB_COUNT: begin
                    nxt_rdata = {24'h00_0000, `STM_RST_PARAM_COUNT};
                    nxt_err = od_req.write;
                end
                `STM_SUB_MODE: begin
                    nxt_rdata = {16'h0000, is_out ? out_mode_ff : in_mode_ff};
                    if (od_req.write) begin
                        nxt_err = (mode_w > `STM_MODE_SYNC1)
                            && (is_out || (mode_w != `STM_MODE_OUT_MGR_EVENT));
                    end
                end
                `STM_SUB_CYCLE: begin
                    nxt_rdata = is_out ? out_cycle_ff : in_cycle_ff;
                end
                `STM_SUB_SHIFT: begin
                    nxt_rdata = is_out ? meas_ff[`STM_M_OUT_SHIFT] : meas_ff[`STM_M_IN_SHIFT];
                    nxt_err = od_req.write;
                end
                `STM_SUB_SUPPORTED: begin
                    nxt_rdata = {16'h0000, `STM_SUPPORTED_MODES};
                    nxt_err = od_req.write;
                end
                `STM_SUB_MIN_CYCLE: begin
                    nxt_rdata = is_out ? meas_ff[`STM_M_OUT_MIN_CYCLE] :
                        meas_ff[`STM_M_IN_MIN_CYCLE];
                    nxt_err = od_req.write;
                end
                `STM_SUB_CALC_COPY: begin
                    nxt_rdata = is_out ? meas_ff[`STM_M_OUT_CALC] : meas_ff[`STM_M_IN_CALC];
                    nxt_err = od_req.write;
                end
                `STM_SUB_MIN_DELAY: begin
                    nxt_err = od_req.write;
                end
                `STM_SUB_COMMAND: begin
                    nxt_rdata = {16'h0000, is_out ? out_cmd_ff : in_cmd_ff};
                    if (od_req.write) begin
                        nxt_err = (mode_w != `STM_CMD_START) && (mode_w != `STM_CMD_STOP);
                    end
                end
                `STM_SUB_MAX_DELAY: begin
                    nxt_rdata = is_out ? meas_ff[`STM_M_OUT_DELAY] : meas_ff[`STM_M_IN_DELAY];
                    nxt_err = od_req.write;
                end
                `STM_SUB_MISSED: begin
                    nxt_rdata = {16'h0000,
                        is_out ? cnt_ff[`STM_C_OUT_MISSED] : cnt_ff[`STM_C_IN_MISSED]};
                    nxt_err = od_req.write;
                end
                `STM_SUB_OVERRUN: begin
                    nxt_rdata = {16'h0000,
                        is_out ? cnt_ff[`STM_C_OUT_OVERRUN] : cnt_ff[`STM_C_IN_OVERRUN]};
                    nxt_err = od_req.write;
                end
                `STM_SUB_SHORT: begin
                    nxt_rdata = {16'h0000,
                        is_out ? cnt_ff[`STM_C_OUT_SHORT] : cnt_ff[`STM_C_IN_SHORT]};
                    nxt_err = od_req.write;
                end
                `STM_SUB_LATE: begin
                    nxt_rdata = {31'h0000_0000, is_out ? out_late_ff : in_late_ff};
                    nxt_err = od_req.write;
                end
                default: begin
                    nxt_err = 1'b1;
                end
            endcase
        end
    end

    // answer one cycle after the request; data is zero on refusal
    always_ff @(posedge clk) begin
        if (srst) begin
            od_ack_ff <= 1'b0;
            od_err_ff <= 1'b0;
            od_rdata_ff <= 32'h0000_0000;
        end else begin
            od_ack_ff <= od_req_valid;
            od_err_ff <= od_req_valid && nxt_err;
            od_rdata_ff <= (od_req_valid && !nxt_err) ? nxt_rdata : 32'h0000_0000;
        end
    end

    a_ack_one_cycle: assert property (@(posedge clk) disable iff (srst)
        od_ack == $past(od_req_valid))
        else $error("od answer not one cycle after request");
    a_min_cycle_ro: assert property (@(posedge clk) disable iff (srst)
        (wr && od_req.subindex == `STM_SUB_MIN_CYCLE && od_req.index == `STM_IDX_OUT)
        |=> od_err && $stable(meas_ff[`STM_M_OUT_MIN_CYCLE]))
        else $error("write to minimum cycle time accepted");
    a_start_clears: assert property (@(posedge clk) disable iff (srst)
        start_meas |=> measuring && (meas_ff[`STM_M_OUT_DELAY] == 32'h0000_0000)
            && (meas_ff[`STM_M_IN_MIN_CYCLE] == 32'h0000_0000))
        else $error("measurement start did not clear values");
    a_max_never_drops: assert property (@(posedge clk) disable iff (srst)
        (measuring && !start_meas) |=> meas_ff[`STM_M_OUT_SHIFT] >= $past(meas_ff[`STM_M_OUT_SHIFT]))
        else $error("measured maximum decreased");
    a_missed_count: assert property (@(posedge clk) disable iff (srst)
        (cnt_inc[`STM_C_OUT_MISSED] && cnt_ff[`STM_C_OUT_MISSED] != `STM_CNT_MAX)
        |=> cnt_ff[`STM_C_OUT_MISSED] == $past(cnt_ff[`STM_C_OUT_MISSED]) + 16'h0001)
        else $error("missed event not counted");
    a_overrun_count: assert property (@(posedge clk) disable iff (srst)
        (op_state && out_start && out_busy_ff && cnt_ff[`STM_C_OUT_OVERRUN] != `STM_CNT_MAX)
        |=> cnt_ff[`STM_C_OUT_OVERRUN] == $past(cnt_ff[`STM_C_OUT_OVERRUN]) + 16'h0001)
        else $error("overrun not counted");
    a_short_idle: assert property (@(posedge clk) disable iff (srst)
        !evt.sync1 |=> $stable(cnt_ff[`STM_C_IN_SHORT]) && $stable(cnt_ff[`STM_C_OUT_SHORT]))
        else $error("short counter moved without SYNC1");
    a_late_flag: assert property (@(posedge clk) disable iff (srst)
        (out_dc_mode && out_start) |=> out_late_ff == $past(out_busy_ff))
        else $error("sync error flag wrong");
    a_cnt_saturate: assert property (@(posedge clk) disable iff (srst)
        cnt_ff[`STM_C_IN_OVERRUN] == `STM_CNT_MAX |=> cnt_ff[`STM_C_IN_OVERRUN] == `STM_CNT_MAX)
        else $error("counter wrapped");

endmodule : sync_timing_monitor

// ---- od_master.sv ----
// od_master.sv: fieldbus master model issuing one object access at a time.
// assumes the monitor acks each access within a few clk cycles.
module od_master (
    input wire logic clk,
    input wire logic od_ack,
    output logic od_req_valid,
    output stm_pkg::od_req_t od_req,
    output logic hung
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        od_req_valid = 1'b0;
        od_req = '0;
        hung = 1'b0;
    end
    task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [31:0] d);
        int i;
        // codes written are chosen by the caller
        @(posedge clk);
        od_req_valid <= 1'b1;
        od_req <= '{w, idx, sub, d};
        @(posedge clk);
        od_req_valid <= 1'b0;
        // released fields must not keep looking valid
        od_req <= ~od_req;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (od_ack !== 1'b1 && i < 4);
        hung = (od_ack !== 1'b1);
    endtask : acc
endmodule : od_master

// ---- tb_top.sv ----
// tb_top.sv: self-checking bench of the sync timing monitor.
// assumes od_master issues accesses; events are driven here one cycle apiece.
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
    $display("unexpected %s expected %h seen %h", nm, e, a); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic op_state = 1'b0;
    stm_pkg::sync_evt_t evt = '0;
    logic od_req_valid, od_ack, od_err, out_dc_mode, in_dc_mode, measuring, hung;
    stm_pkg::od_req_t od_req;
    logic [31:0] od_rdata;
    logic [32:0] exp_q[$];
    logic [32:0] exp_v;
    int n_fail = 0;
    int n_compared = 0;
    integer seed = 32'he56c797f;
    int n1, n2, mx;
    logic [7:0] subs [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
        8'h09, 8'h0b, 8'h0c, 8'h0d, 8'h20};
    logic [31:0] rsts [14] = '{32'h20, 32'h1, 32'hf4240, 32'h0, 32'h3, 32'h186a0, 32'h0,
        32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [31:0] modes [5] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h22};

    always #12.5 clk = ~clk;

    sync_timing_monitor i_sync_timing_monitor (.clk(clk), .srst(srst),
        .od_req_valid(od_req_valid), .od_req(od_req), .od_ack(od_ack), .od_err(od_err),
        .od_rdata(od_rdata), .evt(evt), .op_state(op_state), .out_dc_mode(out_dc_mode),
        .in_dc_mode(in_dc_mode), .measuring(measuring));
    od_master master (.clk(clk), .od_ack(od_ack), .od_req_valid(od_req_valid),
        .od_req(od_req), .hung(hung));

    task automatic give_verdict();
        if (n_fail == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [31:0] d, input logic err, input logic [31:0] rd);
        exp_q.push_back({err, rd});
        master.acc(w, idx, sub, d);
        if (hung === 1'b1) begin
            n_fail++;
            give_verdict();
        end
    endtask : acc

    task automatic tick(input logic [6:0] e);
        @(posedge clk);
        evt <= e;
    endtask : tick

    // sync0, manager event, sync1, then outputs applied n cycles after sync0
    task automatic cycle(input int n);
        tick(7'h40);
        tick(7'h10);
        tick(7'h20);
        repeat (n - 3) tick(7'h00);
        tick(7'h04);
        tick(7'h00);
    endtask : cycle

    always @(posedge clk) begin
        if (od_ack === 1'b1) begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1ffffffff;
            `CHK("od_err", exp_v[32], od_err)
            `CHK("od_rdata", exp_v[31:0], od_rdata)
        end
    end

    initial begin
        int i;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        for (i = 0; i < 14; i++) begin
            acc(0, 16'h1c32, subs[i], 0, 0, rsts[i]);
            acc(0, 16'h1c33, subs[i], 0, 0, (i == 1) ? 32'h22 : rsts[i]);
        end
        acc(1, 16'h1c32, 8'h05, 32'h1, 1, 0);
        acc(1, 16'h1c34, 8'h01, 32'h0, 1, 0);
        acc(1, 16'h1c32, 8'h08, 32'h2, 1, 0);
        acc(1, 16'h1c32, 8'h01, 32'h22, 1, 0);
        acc(1, 16'h1c33, 8'h01, 32'h4, 1, 0);
        for (i = 0; i < 5; i++) begin
            acc(1, 16'h1c33, 8'h01, modes[i], 0, (i == 0) ? 32'h22 : modes[i - 1]);
            acc(0, 16'h1c33, 8'h01, 0, 0, modes[i]);
            `CHK("in_dc_mode", (i == 2 || i == 3), in_dc_mode)
        end
        for (i = 0; i < 4; i++) begin
            acc(1, 16'h1c32, 8'h01, modes[i], 0, (i == 0) ? 32'h1 : modes[i - 1]);
            `CHK("out_dc_mode", (i > 1), out_dc_mode)
        end
        n1 = 4 + {$random(seed)} % 16;
        n2 = 4 + {$random(seed)} % 16;
        mx = (n1 > n2) ? n1 : n2;
        acc(1, 16'h1c33, 8'h08, 32'h1, 0, 0);
        `CHK("measuring", 1'b1, measuring)
        cycle(n1);
        cycle(n2);
        acc(0, 16'h1c32, 8'h03, 0, 0, mx * 25);
        acc(0, 16'h1c32, 8'h05, 0, 0, mx * 25);
        acc(0, 16'h1c32, 8'h06, 0, 0, (mx - 1) * 25);
        acc(0, 16'h1c32, 8'h09, 0, 0, (mx - 2) * 25);
        // the measurement was started on the input set, so it is stopped there
        acc(1, 16'h1c33, 8'h08, 32'h0, 0, 1);
        `CHK("measuring", 1'b0, measuring)
        // a stopped measurement must not pick up the longer cycle
        cycle(mx + 3);
        acc(0, 16'h1c32, 8'h03, 0, 0, mx * 25);
        acc(1, 16'h1c32, 8'h08, 32'h1, 0, 0);
        acc(0, 16'h1c32, 8'h03, 0, 0, 0);
        acc(0, 16'h1c32, 8'h05, 0, 0, 0);
        op_state <= 1'b1;
        tick(7'h40);
        tick(7'h00);
        tick(7'h40);
        tick(7'h00);
        tick(7'h00);
        acc(0, 16'h1c32, 8'h0b, 0, 0, 1);
        acc(0, 16'h1c32, 8'h0c, 0, 0, 1);
        acc(0, 16'h1c32, 8'h20, 0, 0, 1);
        tick(7'h10);
        tick(7'h04);
        tick(7'h40);
        tick(7'h00);
        tick(7'h00);
        acc(0, 16'h1c32, 8'h20, 0, 0, 0);
        acc(0, 16'h1c32, 8'h0d, 0, 0, 2);
        // input side in DC mode: sync0, sync1, sample, ready two cycles later
        acc(1, 16'h1c33, 8'h01, 32'h2, 0, 32'h22);
        tick(7'h40);
        tick(7'h20);
        tick(7'h02);
        tick(7'h00);
        tick(7'h01);
        tick(7'h00);
        acc(0, 16'h1c33, 8'h03, 0, 0, 32'h32);
        acc(0, 16'h1c33, 8'h09, 0, 0, 32'h19);
        acc(0, 16'h1c33, 8'h06, 0, 0, 32'h32);
        acc(0, 16'h1c33, 8'h05, 0, 0, 32'h64);
        // let the checker take the last answer before the verdict
        @(posedge clk);
        if (exp_q.size() != 0) n_fail++;
        give_verdict();
    end
endmodule : tb_top
